// [common/hotswap_consts.svh]
// Timing constants for the hotswap fault sequencer
`ifndef HOTSWAP_CONSTS_SVH
`define HOTSWAP_CONSTS_SVH

`define CLK_PERIOD_PS          8000
`define INSERTION_WAIT_US_X10  137000
// Long delays are worked out in 64-bit arithmetic; 32-bit products would wrap
`define INSERTION_WAIT_CYC     ((`INSERTION_WAIT_US_X10 * 64'd100000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ENABLE_DEGLITCH_NS     6000
`define ENABLE_DEGLITCH_CYC    ((`ENABLE_DEGLITCH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HIGH_VOLTAGE_RESP_PS   1570000
`define HIGH_VOLTAGE_RESP_CYC  (`HIGH_VOLTAGE_RESP_PS / `CLK_PERIOD_PS)
`define FIXED_TRIP_RESP_NS     200
`define SCALED_TRIP_RESP_NS    400
`define BLANK_SHORT_US         400
`define BLANK_SHORT_CYC        ((`BLANK_SHORT_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BLANK_LONG_US          3200
`define BLANK_LONG_CYC         ((`BLANK_LONG_US * 64'd1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STARTUP_TIMEOUT_MS     215
`define STARTUP_TIMEOUT_CYC    ((`STARTUP_TIMEOUT_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define RETRY_WAIT_MS          105
`define RETRY_WAIT_CYC         ((`RETRY_WAIT_MS * 64'd1000000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DRAIN_WAIT_US_X100     466000
`define DRAIN_WAIT_CYC         ((`DRAIN_WAIT_US_X100 * 64'd10000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PG_DELAY_US            20
`define PG_DELAY_CYC           ((`PG_DELAY_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TIMER_WIDTH            32

`endif

// [common/hotswap_pkg.sv]
// Types for the hotswap fault sequencer
package hotswap_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_WAIT_SUPPLY,
      ST_INSERTION,
      ST_SAMPLE_ENABLE,
      ST_RAMP,
      ST_ON,
      ST_FAULT_LATCH,
      ST_RETRY_WAIT
   } seq_state_type;
endpackage : hotswap_pkg

// [hw/enable_deglitch.sv]
// Deglitch filter for the enable level
`timescale 1ns/1ps
`default_nettype none
`include "hotswap_consts.svh"

module enable_deglitch #(
   parameter int unsigned FILTER_CYC = `ENABLE_DEGLITCH_CYC
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic raw_i,      // Raw enable level
   output logic      filtered_o  // Stable enable level
);
   logic [15:0] count_q;          // Cycles the raw level has differed
   logic [15:0] count_d;
   logic        level_q;          // Accepted level
   wire         differs = (raw_i != level_q);
   wire         expired = (count_q >= 16'(FILTER_CYC - 1));

   // Count only while raw differs; short pulses restart the count
   always_comb begin
      count_d = differs ? (expired ? 16'h0000 : count_q + 16'h0001) : 16'h0000;
   end

   // Level flips only after the full filter time
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count_q <= 16'h0000;
         level_q <= 1'b0;
      end else begin
         count_q <= count_d;
         if (differs && expired) begin
            level_q <= raw_i;
         end
      end
   end

   assign filtered_o = level_q;
endmodule : enable_deglitch
`default_nettype wire

// [hw/hotswap_fault_sequencer.sv]
// Hotswap start-up sequencing and fault timing logic
// Operation
// - Hold switch off 13.7 ms after supply good
// - Sample enable after delay; high starts conduction
// - Enable low keeps switch off
// - Deglitch enable for 6 us
// - Overvoltage turns output off within 1.57 us
// - Fixed fast trip cuts within 200 ns
// - Scaled fast trip cuts within 400 ns
// - Blanked overcurrent trips after 400us or 3.2ms
// - Start-up not done in 215 ms flags fault
// - Thermal shutdown forces switch off always
// - Start-up fault latches or retries per configuration
// - Enable in drain band too long drains output
// - Enable below shutdown clears all state
`timescale 1ns/1ps
`default_nettype none
`include "hotswap_consts.svh"

// All timing parameters are cycle counts of the 8 ns timebase
// Defaults give the documented delays; a bench may shorten them
// Pin levels arrive already compared and are taken as synchronous
module hotswap_fault_sequencer
   import hotswap_pkg::*;
#(
   parameter longint unsigned INSERTION_CYC = `INSERTION_WAIT_CYC,
   parameter longint unsigned BLANK_SHORT   = `BLANK_SHORT_CYC,
   parameter longint unsigned BLANK_LONG    = `BLANK_LONG_CYC,
   parameter longint unsigned STARTUP_CYC   = `STARTUP_TIMEOUT_CYC,
   parameter longint unsigned RETRY_CYC     = `RETRY_WAIT_CYC,
   parameter longint unsigned DRAIN_CYC     = `DRAIN_WAIT_CYC,
   parameter int unsigned     ENABLE_DG_CYC = `ENABLE_DEGLITCH_CYC
) (
   input  wire logic clk_i,
   input  wire logic reset_i,                   // Synchronous reset, high
   input  wire logic shutdown_level_i,          // Enable below shutdown level
   input  wire logic enable_threshold_input_i,  // Enable above low-voltage rising level
   input  wire logic input_low_voltage_guard_i, // Supply above low-voltage guard
   input  wire logic input_high_voltage_guard_i,// Supply above high-voltage level
   input  wire logic fixed_trip_i,              // Current above fixed trip level
   input  wire logic scaled_trip_i,             // Current above scaled trip level
   input  wire logic overcurrent_i,             // Current above programmed threshold
   input  wire logic thermal_shutdown_i,        // Junction too hot
   input  wire logic switch_fully_on_i,         // Switch gate fully enhanced
   input  wire logic long_blanking_i,           // Long-blanking variant strap
   input  wire logic auto_retry_i,              // Auto-retry configuration strap
   output logic      internal_switch_enable_o,  // Switch drive request
   output logic      output_ramp_control_o,     // Ramp generator enable
   output logic      fault_indicator_output_o,  // High when good, low on fault
   output logic      power_good_output_o,       // Power good
   output logic      quick_output_drain_o       // Output discharge enable
);
   localparam int TW = `TIMER_WIDTH;

   seq_state_type state_q, state_d;     // Sequencer state
   logic [TW-1:0] timer_q, timer_d;     // Shared sequencing timer
   logic [TW-1:0] blank_q;              // Overcurrent blanking counter
   logic [TW-1:0] pg_q;                 // Power-good delay counter
   logic [TW-1:0] drain_q;              // Discharge band counter
   logic          fault_q;              // Latched fault indicator
   logic          pg_out_q;             // Registered power good
   logic          drain_q_out;          // Registered discharge enable
   logic          switch_q;             // Registered switch enable
   logic          ramp_q;               // Registered ramp enable
   logic          long_sel_q;           // Blanking variant captured at release of reset or shutdown level
   logic          retry_sel_q;          // Retry mode captured at release of reset or shutdown level
   logic          enable_ok;            // Deglitched enable

   // Shutdown level acts as a full clear alongside reset
   wire clear_all = reset_i | shutdown_level_i;

   enable_deglitch #(
      .FILTER_CYC (ENABLE_DG_CYC)
   ) u_enable_deglitch (
      .clk_i      (clk_i),
      .reset_i    (clear_all),
      .raw_i      (enable_threshold_input_i),
      .filtered_o (enable_ok)
   );

   // Immediate kill terms; each acts in the very next cycle, well inside its time
   // One cycle is 8 ns, so even the 200 ns trip has a wide margin
   wire fast_kill  = input_high_voltage_guard_i
                   | fixed_trip_i
                   | scaled_trip_i;
   // Blanking limit follows the variant captured at the last clear
   wire blank_lim_hit = (blank_q >= TW'(long_sel_q ? BLANK_LONG - 1 : BLANK_SHORT - 1));
   // Trip needs the overcurrent still present at the limit
   wire blank_trip = overcurrent_i & blank_lim_hit;
   // Timer end points; the shared timer is zero on entry to ST_INSERTION, ST_RAMP and ST_RETRY_WAIT
   wire timer_done_ins   = (timer_q >= TW'(INSERTION_CYC - 1));
   wire timer_done_su    = (timer_q >= TW'(STARTUP_CYC - 1));
   wire timer_done_retry = (timer_q >= TW'(RETRY_CYC - 1));
   // Off band: filtered enable low with the switch already open
   // Shutdown level is not part of it, since that clears everything
   wire drain_band = ~enable_ok & ~switch_q;
   // Power-good delay end point
   wire pg_done  = (pg_q >= TW'(`PG_DELAY_CYC - 1));

   // Next-state decode
   always_comb begin
      state_d = state_q;
      timer_d = timer_q + TW'(1);
      case (state_q)
         ST_WAIT_SUPPLY: begin
            // Timer parked at zero until the supply qualifies
            timer_d = '0;
            if (input_low_voltage_guard_i) begin
               state_d = ST_INSERTION;
            end
         end
         ST_INSERTION: begin
            // Switch held off regardless of enable
            if (!input_low_voltage_guard_i) begin
               state_d = ST_WAIT_SUPPLY;
            end else if (timer_done_ins) begin
               state_d = ST_SAMPLE_ENABLE;
            end
         end
         ST_SAMPLE_ENABLE: begin
            // Timer cleared so the start-up timeout counts from the ramp
            timer_d = '0;
            if (!input_low_voltage_guard_i) begin
               state_d = ST_WAIT_SUPPLY;
            end else if (enable_ok && !fast_kill && !thermal_shutdown_i) begin
               state_d = ST_RAMP;
            end
         end
         ST_RAMP: begin
            // Ramp ends on full enhancement, a kill term or the timeout
            // Kills win over a timeout in the same cycle: no fault is flagged
            if (!enable_ok || !input_low_voltage_guard_i || fast_kill || thermal_shutdown_i) begin
               state_d = ST_SAMPLE_ENABLE;
            end else if (switch_fully_on_i) begin
               state_d = ST_ON;
            end else if (timer_done_su) begin
               timer_d = '0;
               state_d = retry_sel_q ? ST_RETRY_WAIT : ST_FAULT_LATCH;
            end
         end
         ST_ON: begin
            // Steady state; the blanking counter runs beside this state
            timer_d = '0;
            if (blank_trip) begin
               state_d = retry_sel_q ? ST_RETRY_WAIT : ST_FAULT_LATCH;
            end else if (!enable_ok || !input_low_voltage_guard_i || fast_kill || thermal_shutdown_i) begin
               // Overvoltage recovery restarts a controlled ramp
               state_d = ST_SAMPLE_ENABLE;
            end
         end
         ST_FAULT_LATCH: begin
            // Only reset or the shutdown level clears a latched fault
            timer_d = '0;
         end
         ST_RETRY_WAIT: begin
            // Switch stays open for the whole retry interval
            if (timer_done_retry) begin
               state_d = ST_SAMPLE_ENABLE;
            end
         end
         default: begin
            // Unused encodings fall back to the safe supply wait
            state_d = ST_WAIT_SUPPLY;
         end
      endcase
   end

   // Sequencer registers
   // Shutdown level clears like reset, so no state survives it
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         state_q <= ST_WAIT_SUPPLY;
         timer_q <= '0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
      end
   end

   // Straps captured by a clocked process while cleared
   // A strap change takes effect only after the next clear
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         long_sel_q  <= long_blanking_i;
         retry_sel_q <= auto_retry_i;
      end
   end

   // Blanking counter runs only while overcurrent persists in steady state
   always_ff @(posedge clk_i) begin
      if (clear_all || !overcurrent_i || state_q != ST_ON) begin
         blank_q <= '0;
      end else if (!blank_lim_hit) begin
         blank_q <= blank_q + TW'(1);
      end
   end

   // Switch and ramp drive; off in the cycle after any kill term
   // Kill terms gate the flop directly, not only through the state
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         switch_q <= 1'b0;
         ramp_q   <= 1'b0;
      end else begin
         switch_q <= (state_d == ST_RAMP || state_d == ST_ON)
                     & ~thermal_shutdown_i
                     & ~fast_kill
                     & enable_ok;
         ramp_q   <= (state_d == ST_RAMP);
      end
   end

   // Fault indicator: set by start-up timeout or breaker trip; set wins
   // Set and clear come from different states, so they never collide
   always_ff @(posedge clk_i) begin
      if (clear_all) begin
         fault_q <= 1'b0;
      end else if ((state_q == ST_RAMP && state_d != ST_SAMPLE_ENABLE && timer_done_su && !switch_fully_on_i)
                   || (state_q == ST_ON && blank_trip)) begin
         fault_q <= 1'b1;
      end else if (state_q == ST_RETRY_WAIT && timer_done_retry) begin
         fault_q <= 1'b0;
      end
   end

   // Power good delay after fully on; drops on any shutdown
   always_ff @(posedge clk_i) begin
      if (clear_all || state_q != ST_ON || state_d != ST_ON) begin
         pg_q     <= '0;
         pg_out_q <= 1'b0;
      end else begin
         if (!pg_done) begin
            pg_q <= pg_q + TW'(1);
         end
         pg_out_q <= pg_done;
      end
   end

   // Discharge after enable has sat in the off band long enough
   // Counter holds at its limit so the discharge stays on in the band
   always_ff @(posedge clk_i) begin
      if (clear_all || !drain_band) begin
         drain_q     <= '0;
         drain_q_out <= 1'b0;
      end else if (drain_q >= TW'(DRAIN_CYC - 1)) begin
         drain_q_out <= 1'b1;
      end else begin
         drain_q <= drain_q + TW'(1);
      end
   end

   // Outputs come straight from flops
   // Fault pin is low when a fault is latched
   // Power good is high only with the fault clear; discharge can be high while a fault is latched
   assign internal_switch_enable_o = switch_q;
   assign output_ramp_control_o    = ramp_q;
   assign fault_indicator_output_o = ~fault_q;
   assign power_good_output_o      = pg_out_q;
   assign quick_output_drain_o     = drain_q_out;
endmodule : hotswap_fault_sequencer
`default_nettype wire

// [tb/board_model.sv]
// Board-side model: load reaches full enhancement some cycles after switch-on
`timescale 1ns/1ps
`default_nettype none
module board_model (
   input  wire logic       clk_i,
   input  wire logic       switch_on_i,
   input  wire logic [7:0] rise_cyc_i,  // Cycles to full on, 0 = never
   output logic            fully_on_o
);
   logic [7:0] cnt_q;  // Cycles since switch-on
   // Full enhancement only while driven; drops as soon as the switch opens
   always_ff @(posedge clk_i) begin
      cnt_q      <= switch_on_i ? cnt_q + {7'h0, cnt_q != 8'hff} : 8'h00;
      fully_on_o <= switch_on_i && rise_cyc_i != 8'h00 && cnt_q >= rise_cyc_i;
   end
endmodule : board_model
`default_nettype wire

// [tb/hotswap_fault_sequencer_asserts.sv]
// Port-level timing checks for the hotswap sequencer
`timescale 1ns/1ps
`default_nettype none
module hotswap_fault_sequencer_asserts #(
   parameter longint INS = 20, BS = 10, BL = 40, SU = 50, DR = 15
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic shutdown_level_i,
   input wire logic enable_threshold_input_i,
   input wire logic input_low_voltage_guard_i,
   input wire logic input_high_voltage_guard_i,
   input wire logic fixed_trip_i,
   input wire logic scaled_trip_i,
   input wire logic overcurrent_i,
   input wire logic thermal_shutdown_i,
   input wire logic long_blanking_i,
   input wire logic auto_retry_i,
   input wire logic internal_switch_enable_o,
   input wire logic output_ramp_control_o,
   input wire logic fault_indicator_output_o,
   input wire logic power_good_output_o,
   input wire logic quick_output_drain_o
);
   logic       clr;                        // Any full clear
   logic [7:0] sup_q, ramp_q, oc_q, low_q; // Saturating run counters
   assign clr = reset_i | shutdown_level_i;
   // Run lengths; saturate so a long run never wraps to a small count
   always_ff @(posedge clk_i) begin
      sup_q  <= (clr | !input_low_voltage_guard_i) ? 8'h00 : sup_q + {7'h0, sup_q != 8'hff};
      ramp_q <= (clr | !output_ramp_control_o) ? 8'h00 : ramp_q + {7'h0, ramp_q != 8'hff};
      oc_q   <= (clr | !overcurrent_i | !internal_switch_enable_o | output_ramp_control_o) ? 8'h00 :
                oc_q + {7'h0, oc_q != 8'hff};
      low_q  <= (clr | enable_threshold_input_i | internal_switch_enable_o) ? 8'h00 : low_q + {7'h0, low_q != 8'hff};
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_insert_wait: assert property ($rose(internal_switch_enable_o) |-> sup_q >= INS)
      else $error("switch rose inside the insertion wait");
   a_volt_kill: assert property (input_high_voltage_guard_i || thermal_shutdown_i |=> !internal_switch_enable_o)
      else $error("switch not off one cycle after voltage or heat kill");
   a_trip_kill: assert property (fixed_trip_i || scaled_trip_i |=> !internal_switch_enable_o)
      else $error("switch not off one cycle after fast trip");
   a_enable_off: assert property (!enable_threshold_input_i [*6] |=> !internal_switch_enable_o)
      else $error("switch on with enable held low");
   a_clear_all: assert property (shutdown_level_i |=> !internal_switch_enable_o && !output_ramp_control_o &&
      fault_indicator_output_o && !power_good_output_o && !quick_output_drain_o)
      else $error("shutdown level did not clear outputs");
   a_ramp_bound: assert property (ramp_q <= SU + 2)
      else $error("ramp outlived the start-up timeout");
   a_breaker_bound: assert property (oc_q <= (long_blanking_i ? BL : BS) + 2)
      else $error("overcurrent outlived the blanking time");
   a_pg_good: assert property (power_good_output_o |-> internal_switch_enable_o && fault_indicator_output_o)
      else $error("power good without switch or with fault");
   a_latch_off: assert property (!fault_indicator_output_o && !auto_retry_i && !shutdown_level_i
      |=> !fault_indicator_output_o)
      else $error("latched fault released without clear");
   a_drain_wait: assert property ($rose(quick_output_drain_o) |-> low_q >= DR && !internal_switch_enable_o)
      else $error("drain started early or with switch on");
   c_fault: cover property ($fell(fault_indicator_output_o));
   c_good: cover property ($rose(power_good_output_o));
   c_drain: cover property ($rose(quick_output_drain_o));
endmodule : hotswap_fault_sequencer_asserts
`default_nettype wire

// [tb/hotswap_fault_sequencer_tb_top.sv]
// Self-checking bench for the hotswap sequencer
`timescale 1ns/1ps
`default_nettype none
module hotswap_fault_sequencer_tb_top;
   localparam int INS = 20, BS = 10, BL = 40, SU = 50, RT = 30, DR = 15, PGD = 2500;
   typedef struct {logic [4:0] v; int lo;} note_type;  // Expected outputs, earliest cycle
   logic clk_i = 0, reset_i = 1, shutdown_level_i = 0, enable_threshold_input_i = 1, input_low_voltage_guard_i = 1;
   logic input_high_voltage_guard_i = 0, fixed_trip_i = 0, scaled_trip_i = 0, overcurrent_i = 0;
   logic thermal_shutdown_i = 0, long_blanking_i = 0, auto_retry_i = 0, switch_fully_on_i;
   wire  internal_switch_enable_o, output_ramp_control_o, fault_indicator_output_o, power_good_output_o;
   wire  quick_output_drain_o;
   logic [7:0]  rise = 8'h06;       // Partner full-on delay
   logic [31:0] seed = 32'hf984;    // Random state
   logic [4:0]  vec, prev;          // Output snapshot
   note_type    q[$], n;            // Expectation queue
   int          cyc = 0, fails = 0, tests_run = 0, k;
   bit          armed = 0;
   assign vec = {internal_switch_enable_o, output_ramp_control_o, fault_indicator_output_o, power_good_output_o,
                 quick_output_drain_o};
   hotswap_fault_sequencer #(.INSERTION_CYC(INS), .BLANK_SHORT(BS), .BLANK_LONG(BL), .STARTUP_CYC(SU),
      .RETRY_CYC(RT), .DRAIN_CYC(DR), .ENABLE_DG_CYC(4)) u_hotswap_fault_sequencer (
      .clk_i(clk_i), .reset_i(reset_i), .shutdown_level_i(shutdown_level_i),
      .enable_threshold_input_i(enable_threshold_input_i), .input_low_voltage_guard_i(input_low_voltage_guard_i),
      .input_high_voltage_guard_i(input_high_voltage_guard_i), .fixed_trip_i(fixed_trip_i),
      .scaled_trip_i(scaled_trip_i), .overcurrent_i(overcurrent_i), .thermal_shutdown_i(thermal_shutdown_i),
      .switch_fully_on_i(switch_fully_on_i), .long_blanking_i(long_blanking_i), .auto_retry_i(auto_retry_i),
      .internal_switch_enable_o(internal_switch_enable_o), .output_ramp_control_o(output_ramp_control_o),
      .fault_indicator_output_o(fault_indicator_output_o), .power_good_output_o(power_good_output_o),
      .quick_output_drain_o(quick_output_drain_o));
   board_model u_board_model (.clk_i(clk_i), .switch_on_i(internal_switch_enable_o), .rise_cyc_i(rise),
      .fully_on_o(switch_fully_on_i));
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic err(string m);
      fails++;
      $display("[ERR] %0t %s", $time, m);
   endtask : err
   task automatic exp(logic [4:0] v, int lo);
      q.push_back('{v, lo});
   endtask : exp
   task automatic tick(int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask : tick
   task automatic up(int lo);  // Ramp, full on, then power good
      exp(5'b11100, lo);
      exp(5'b10100, 0);
      exp(5'b10110, lo + PGD);
   endtask : up
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic settle(string name);  // Bounded wait for the queue to drain
      int i;
      for (i = 0; i < 6000 && q.size() != 0; i++) tick(1);
      if (q.size() != 0) begin
         err("timeout");
         summarize();
      end else begin
         tick(8);
         $display("done %s", name);
      end
   endtask : settle
   // Watcher: each output change takes the oldest note
   always @(negedge clk_i) if (armed && vec !== prev) begin
      prev = vec;
      tests_run++;
      if (q.size() == 0) err("unexpected output change");
      else begin
         n = q.pop_front();
         if (vec !== n.v || cyc < n.lo) err("output change wrong or early");
      end
   end
   initial begin
      tick(16);
      tests_run++;
      if (vec !== 5'b00100) err("reset outputs");
      reset_i = 0;
      prev = vec;
      armed = 1;
      up(cyc + INS);
      settle("power up");
      enable_threshold_input_i = 0;
      tick(2);
      enable_threshold_input_i = 1;
      settle("glitch");
      for (k = 0; k < 5; k++) begin
         seed = xs(seed);
         rise = {4'h0, seed[3:0]} + 8'h01;
         exp(5'b00100, cyc + 1);
         {enable_threshold_input_i, input_high_voltage_guard_i, fixed_trip_i, scaled_trip_i,
          thermal_shutdown_i} = 5'b10000 ^ (5'b10000 >> k);
         tick(6 + int'(seed[5:4]));
         {enable_threshold_input_i, input_high_voltage_guard_i, fixed_trip_i, scaled_trip_i,
          thermal_shutdown_i} = 5'b10000;
         up(cyc + 1);
         settle("kill");
      end
      overcurrent_i = 1;
      tick(BS - 3);
      overcurrent_i = 0;
      tick(4);
      exp(5'b00000, cyc + BS);
      overcurrent_i = 1;
      settle("breaker");
      overcurrent_i = 0;
      tick(3 * RT);
      settle("latch off");
      shutdown_level_i = 1;
      long_blanking_i = 1;
      auto_retry_i = 1;
      rise = 8'h00;
      exp(5'b00100, cyc);
      tick(3);
      shutdown_level_i = 0;
      exp(5'b11100, cyc + INS);
      exp(5'b00000, cyc + INS + SU);
      settle("start timeout");
      rise = 8'h05;
      exp(5'b00100, cyc + RT - 10);
      up(0);
      settle("retry");
      exp(5'b00000, cyc + BL);
      overcurrent_i = 1;
      settle("long breaker");
      overcurrent_i = 0;
      exp(5'b00100, cyc + RT - 10);
      up(0);
      settle("retry after trip");
      exp(5'b00100, cyc + 1);
      exp(5'b00101, cyc + DR);
      enable_threshold_input_i = 0;
      settle("drain");
      exp(5'b00100, cyc + 1);
      up(cyc + 1);
      thermal_shutdown_i = 1;
      enable_threshold_input_i = 1;
      tick(8);
      thermal_shutdown_i = 0;
      settle("drain exit");
      summarize();
   end
endmodule : hotswap_fault_sequencer_tb_top
bind hotswap_fault_sequencer hotswap_fault_sequencer_asserts #(.INS(INSERTION_CYC), .BS(BLANK_SHORT),
   .BL(BLANK_LONG), .SU(STARTUP_CYC), .DR(DRAIN_CYC)) u_hotswap_fault_sequencer_asserts (
   .clk_i(clk_i), .reset_i(reset_i), .shutdown_level_i(shutdown_level_i),
   .enable_threshold_input_i(enable_threshold_input_i), .input_low_voltage_guard_i(input_low_voltage_guard_i),
   .input_high_voltage_guard_i(input_high_voltage_guard_i), .fixed_trip_i(fixed_trip_i),
   .scaled_trip_i(scaled_trip_i), .overcurrent_i(overcurrent_i), .thermal_shutdown_i(thermal_shutdown_i),
   .long_blanking_i(long_blanking_i), .auto_retry_i(auto_retry_i),
   .internal_switch_enable_o(internal_switch_enable_o), .output_ramp_control_o(output_ramp_control_o),
   .fault_indicator_output_o(fault_indicator_output_o), .power_good_output_o(power_good_output_o),
   .quick_output_drain_o(quick_output_drain_o));
`default_nettype wire
